/* hw/npr_partner_np.sv */
// partner next page ability register with toggle check and page-received flag
// assumes page inputs come from same-clock receiver logic; manager strobes are single cycle
`timescale 1ns/1ps
module npr_partner_np (
	// clock, reset, enable
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	// page receiver side
	input  wire logic              base_page_valid,
	input  wire logic [15:0]       base_page_word,
	input  wire logic              next_page_valid,
	input  wire npr_pkg::npr_word_t next_page_word,
	// management port
	input  wire npr_pkg::npr_req_t mgmt_req,
	output logic [15:0]            mgmt_rdata,
	// status
	output logic                   page_received,
	output logic                   toggle_error
);
	import npr_pkg::*;

	// ==========================================================
	// state
	npr_word_t  word_r, word_nxt;
	npr_state_t st_r, st_nxt;
	logic       exp_tog_r, exp_tog_nxt;
	logic       page_rx_r, page_rx_nxt;
	logic       tog_err_r, tog_err_nxt;
	logic [15:0] rdata_r, rdata_nxt;

	// one word of stored value with reserved bit forced low
	function automatic npr_word_t clean_word(input npr_word_t w);
		npr_word_t c;
		c = w;
		c.reserved = 1'b0;
		return c;
	endfunction : clean_word

	// true when this request is a read of the given register
	// shared by the flag clear and the checks so they agree on decode
	function automatic logic reads_reg(input npr_req_t r, input logic [4:0] a);
		return r.rd && (r.addr == a);
	endfunction : reads_reg

	// expansion word as seen by the manager
	// only the page-received bit is modelled here, every other bit reads zero
	function automatic logic [15:0] expansion_word(input logic flag);
		logic [15:0] e;
		e = 16'h0000;
		e[NPR_POS_PAGE_RX] = flag;
		return e;
	endfunction : expansion_word

	// ==========================================================
	// capture and toggle tracking
	always_comb begin
		word_nxt    = word_r;
		st_nxt      = st_r;
		exp_tog_nxt = exp_tog_r;
		page_rx_nxt = page_rx_r;
		tog_err_nxt = tog_err_r;
		// an expansion read clears the latched flag
		if (reads_reg(mgmt_req, NPR_ADDR_EXPANSION)) begin
			page_rx_nxt = 1'b0;
		end
		if (base_page_valid) begin
			// first next page toggle is inverse of base bit 11
			exp_tog_nxt = ~base_page_word[NPR_BASE_TOGGLE_POS];
			st_nxt      = NPR_ST_NEXT;
			page_rx_nxt = 1'b1; // set wins over clear
		end else if (next_page_valid) begin
			case (st_r)
				NPR_ST_NEXT: begin
					if (next_page_word.toggle == exp_tog_r) begin
						// whole word at once, never mixed
						word_nxt    = clean_word(next_page_word);
						exp_tog_nxt = ~exp_tog_r;
						page_rx_nxt = 1'b1;
						tog_err_nxt = 1'b0;
					end else begin
						tog_err_nxt = 1'b1;
					end
				end
				NPR_ST_BASE: begin
					tog_err_nxt = 1'b1;
				end
				default: begin
					st_nxt = NPR_ST_BASE;
				end
			endcase
		end
	end

	// capture registers; a low enable freezes every one of them
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			word_r    <= NPR_RESET_WORD;
			st_r      <= NPR_ST_BASE;
			exp_tog_r <= 1'b0;
			page_rx_r <= 1'b0;
			tog_err_r <= 1'b0;
		end else if (clk_en) begin
			word_r    <= word_nxt;
			st_r      <= st_nxt;
			exp_tog_r <= exp_tog_nxt;
			page_rx_r <= page_rx_nxt;
			tog_err_r <= tog_err_nxt;
		end
	end

	// ==========================================================
	// read path; writes never touch the stored word
	always_comb begin
		rdata_nxt = 16'h0000;
		if (mgmt_req.rd) begin
			case (mgmt_req.addr)
				NPR_ADDR_PARTNER_NP: rdata_nxt = word_r;
				NPR_ADDR_EXPANSION:  rdata_nxt = expansion_word(page_rx_r);
				default:             rdata_nxt = 16'h0000;
			endcase
		end
	end

	// read data register; with clk_en high it stands for exactly the cycle after the strobe, a low enable holds it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 16'h0000;
		end else if (clk_en) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign mgmt_rdata    = rdata_r;
	assign page_received = page_rx_r;
	assign toggle_error  = tog_err_r;

	// ==========================================================
	// checks
	// the properties below watch the inputs, the registered state and the outputs;
	// the page and read antecedents carry clk_en so a frozen edge never counts as an event,
	// and the asynchronous reset disables them all while it is low

	// helper terms: a page that passes the toggle check and one that is refused
	// kept as plain nets so that $past can look back at them
	logic good_page_w;
	logic bad_page_w;

	// accepted page: enabled edge, no base page beside it, tracker armed, toggle matches
	assign good_page_w = clk_en && !base_page_valid && next_page_valid
		&& st_r == NPR_ST_NEXT && next_page_word.toggle == exp_tog_r;
	// refused page: any other enabled next page that has no base page beside it
	assign bad_page_w  = clk_en && !base_page_valid && next_page_valid && !good_page_w;

	// step one of a load: an accepted next page on an enabled edge
	sequence good_page_s;
		good_page_w;
	endsequence

	// step one of a refusal: a next page that fails the toggle or comes too early
	sequence bad_page_s;
		bad_page_w;
	endsequence

	// step two of a refusal: error flag raised and the stored word untouched
	sequence refused_after_s;
		toggle_error && $stable(word_r);
	endsequence

	// step one of a read of this register on an enabled edge
	sequence np_read_s;
		clk_en && reads_reg(mgmt_req, NPR_ADDR_PARTNER_NP);
	endsequence

	// step one of a read of the expansion register on an enabled edge
	sequence exp_read_s;
		clk_en && reads_reg(mgmt_req, NPR_ADDR_EXPANSION);
	endsequence

	// a write never reaches the stored word; a page landing at the same edge
	// is the only thing allowed to change it, so such edges are left out
	property write_ignored_p;
		@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && mgmt_req.wr && !next_page_valid) |=> $stable(word_r);
	endproperty

	// ----- contents of the stored word
	reserved_reads_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		word_r[NPR_POS_RSVD] == 1'b0) else $error("reserved bit set");
	write_no_effect_a: assert property (write_ignored_p)
		else $error("write changed register");
	whole_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		good_page_s |=> (word_r[10:0] == $past(next_page_word.code_field)
			&& word_r[NPR_POS_MORE] == $past(next_page_word.more_pages_flag)))
		else $error("page not loaded whole");
	msg_flag_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		good_page_s |=> word_r[NPR_POS_MSG] == $past(next_page_word.message_format_flag))
		else $error("message flag wrong");
	acknowledge_two_flag_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		good_page_s |=> word_r[NPR_POS_ACKNOWLEDGE_TWO_FLAG] == $past(next_page_word.acknowledge_two_flag))
		else $error("ack two flag wrong");
	// the word changes only at an edge that accepted a page, never piecemeal
	word_change_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$changed(word_r) |-> $past(good_page_w))
		else $error("word changed without a page");

	// ----- toggle tracking
	toggle_alt_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		good_page_s |=> exp_tog_r == !word_r[NPR_POS_TOGGLE])
		else $error("toggle did not alternate");
	first_toggle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && base_page_valid)
			|=> exp_tog_r == !$past(base_page_word[NPR_BASE_TOGGLE_POS]))
		else $error("first toggle wrong");
	// a refused page raises the error flag and leaves the word alone
	refused_page_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		bad_page_s |=> refused_after_s)
		else $error("refused page was stored");
	// a next page before any base page is always refused
	early_page_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(bad_page_w && st_r == NPR_ST_BASE) |=> toggle_error)
		else $error("early next page accepted");
	// an accepted page clears an earlier error
	err_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		good_page_s |=> !toggle_error)
		else $error("error flag not cleared");
	// a base page arms the tracker for the first next page
	base_arms_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && base_page_valid) |=> st_r == NPR_ST_NEXT)
		else $error("base page did not arm");
	// the tracker only ever holds one of its two one-hot codes
	state_onehot_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		st_r == NPR_ST_BASE || st_r == NPR_ST_NEXT)
		else $error("tracker state illegal");

	// ----- page-received flag
	page_rx_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		good_page_s |=> page_received ##1 (page_received || $past(mgmt_req.rd)))
		else $error("page received not set");
	rx_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(exp_read_s and (!base_page_valid && !next_page_valid)) |=> !page_received)
		else $error("expansion read did not clear");
	base_sets_rx_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && base_page_valid) |=> page_received)
		else $error("base page did not set flag");
	// the flag rises only at an edge that took a page
	rx_rise_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(page_received) |-> $past(clk_en && (base_page_valid || next_page_valid)))
		else $error("flag rose without a page");
	// once set the flag latches until an expansion read takes it down
	rx_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(page_received && !(clk_en && reads_reg(mgmt_req, NPR_ADDR_EXPANSION)))
			|=> page_received)
		else $error("flag dropped without a read");

	// ----- management read path
	read_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		np_read_s |=> mgmt_rdata == $past(word_r))
		else $error("read data wrong");
	code_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		np_read_s |=> mgmt_rdata[10:0] == $past(word_r[10:0]))
		else $error("code field read wrong");
	rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		np_read_s |=> mgmt_rdata[NPR_POS_RSVD] == 1'b0)
		else $error("reserved bit read as one");
	exp_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		exp_read_s |=> mgmt_rdata == {14'h0000, $past(page_rx_r), 1'b0})
		else $error("expansion read wrong");
	// read data stand for one cycle only and read zero otherwise
	no_read_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && !mgmt_req.rd) |=> mgmt_rdata == 16'h0000)
		else $error("read data not zero");

	// ----- clock enable
	// a low enable freezes every register, the read data included
	freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!clk_en |=> ($stable(word_r) && $stable(st_r) && $stable(exp_tog_r)
			&& $stable(page_rx_r) && $stable(tog_err_r) && $stable(rdata_r)))
		else $error("state moved while frozen");
endmodule : npr_partner_np

/* include/npr_pkg.sv */
// package for the partner next page register bank
// assumes a single 125 MHz clock, one management port and an upstream page receiver
package npr_pkg;
	// ==========================================================
	// addresses and widths
	localparam logic [4:0]  NPR_ADDR_PARTNER_NP = 5'h08;
	localparam logic [4:0]  NPR_ADDR_EXPANSION  = 5'h06;
	localparam logic [15:0] NPR_RESET_WORD      = 16'h0000;
	localparam int          NPR_POS_MORE        = 15;
	localparam int          NPR_POS_RSVD        = 14;
	localparam int          NPR_POS_MSG         = 13;
	localparam int          NPR_POS_ACKNOWLEDGE_TWO_FLAG        = 12;
	localparam int          NPR_POS_TOGGLE      = 11;
	localparam int          NPR_POS_PAGE_RX     = 1;
	localparam int          NPR_BASE_TOGGLE_POS = 11;

	// ==========================================================
	// received next page code word layout
	typedef struct packed {
		logic        more_pages_flag;
		logic        reserved;
		logic        message_format_flag;
		logic        acknowledge_two_flag;
		logic        toggle;
		logic [10:0] code_field;
	} npr_word_t;

	// management port request
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} npr_req_t;

	// toggle tracker states
	typedef enum logic [1:0] {
		NPR_ST_BASE = 2'b01,
		NPR_ST_NEXT = 2'b10
	} npr_state_t;
endpackage : npr_pkg

/* tb/npr_mgr_model.sv */
// station manager model for the management port
// assumes one clock; strobes change just after the rising edge
`timescale 1ns/1ps
module npr_mgr_model (
	// clock and read data
	input  wire logic         sys_clk,
	input  wire logic [15:0]  mgmt_rdata,
	// request
	output npr_pkg::npr_req_t mgmt_req
);
	import npr_pkg::*;
	// ==========================================================
	// bus cycles
	initial mgmt_req = '0;
	// one-cycle write, reserved bit 14 kept at its zero default
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		mgmt_req <= '{a, d & 16'hbfff, 1'b1, 1'b0};
		@(posedge sys_clk);
		mgmt_req <= '0;
	endtask : wr
	// one-cycle read, data taken in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		@(posedge sys_clk);
		mgmt_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge sys_clk);
		mgmt_req <= '0;
		#1 q = mgmt_rdata;
	endtask : rd
endmodule : npr_mgr_model

/* tb/npr_partner_np_tb_top.sv */
// self-checking bench for the partner next page register
// assumes the package and the manager model are compiled first
`timescale 1ns/1ps
module npr_partner_np_tb_top;
	import npr_pkg::*;
	// ==========================================================
	// signals
	logic        sys_clk, arst_n, clk_en, base_page_valid, next_page_valid;
	logic [15:0] base_page_word, mgmt_rdata, q;
	npr_word_t   next_page_word;
	npr_req_t    mgmt_req;
	logic        page_received, toggle_error;
	int          fail_count, n_checks;
	// rows: received word, expected register, expected error flag
	logic [15:0] row_in [4]  = '{16'h8805, 16'h7123, 16'h0456, 16'h0fff};
	logic [15:0] row_exp [4] = '{16'h8805, 16'h3123, 16'h3123, 16'h0fff};
	logic        row_err [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

	npr_partner_np i_npr_partner_np (.sys_clk, .arst_n, .clk_en, .base_page_valid,
		.base_page_word, .next_page_valid, .next_page_word, .mgmt_req, .mgmt_rdata,
		.page_received, .toggle_error);
	npr_mgr_model i_npr_mgr_model (.sys_clk, .mgmt_rdata, .mgmt_req);

	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one-cycle page pulse, state settled on return
	task automatic page(input logic base, input logic [15:0] w);
		@(posedge sys_clk);
		base_page_valid <= base;
		next_page_valid <= ~base;
		base_page_word  <= w;
		next_page_word  <= w;
		@(posedge sys_clk);
		base_page_valid <= 1'b0;
		next_page_valid <= 1'b0;
		#1;
	endtask : page
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
	// main sequence
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		base_page_valid = 1'b0;
		next_page_valid = 1'b0;
		base_page_word = '0;
		next_page_word = '0;
		fail_count = 0;
		n_checks = 0;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		i_npr_mgr_model.rd(5'h08, q);
		chk(q, 16'h0000);
		// next page before any base page is refused
		page(1'b0, 16'h8805);
		chk({15'h0, toggle_error}, 16'h0001);
		// base page with bit 11 clear; expansion read clears the flag
		page(1'b1, 16'h0000);
		chk({15'h0, page_received}, 16'h0001);
		i_npr_mgr_model.rd(5'h06, q);
		chk(q, 16'h0002);
		chk({15'h0, page_received}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			page(1'b0, row_in[i]);
			chk({15'h0, toggle_error}, {15'h0, row_err[i]});
			i_npr_mgr_model.rd(5'h08, q);
			chk(q, row_exp[i]);
		end
		// writes ignored, unmapped address reads zero
		i_npr_mgr_model.wr(5'h08, 16'hffff);
		i_npr_mgr_model.rd(5'h08, q);
		chk(q, 16'h0fff);
		i_npr_mgr_model.rd(5'h1f, q);
		chk(q, 16'h0000);
		// frozen enable: a matching page is ignored while clk_en is low
		clk_en <= 1'b0;
		page(1'b0, 16'h0001);
		clk_en <= 1'b1;
		chk({15'h0, toggle_error}, 16'h0000);
		i_npr_mgr_model.rd(5'h08, q);
		chk(q, 16'h0fff);
		page(1'b0, 16'h0001);
		i_npr_mgr_model.rd(5'h08, q);
		chk(q, 16'h0001);
		// page stored at the edge of an expansion read: set wins
		fork
			page(1'b0, 16'h0800);
			i_npr_mgr_model.rd(5'h06, q);
		join
		chk(q, 16'h0002);
		chk({15'h0, page_received}, 16'h0001);
		// mid-run reset, then a base page with bit 11 set
		arst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		i_npr_mgr_model.rd(5'h08, q);
		chk(q, 16'h0000);
		chk({15'h0, page_received}, 16'h0000);
		page(1'b1, 16'h0800);
		page(1'b0, 16'h0800);
		chk({15'h0, toggle_error}, 16'h0001);
		page(1'b0, 16'h2000);
		chk({15'h0, toggle_error}, 16'h0000);
		i_npr_mgr_model.rd(5'h08, q);
		chk(q, 16'h2000);
		give_verdict();
	end
endmodule : npr_partner_np_tb_top
